// [hdl/pa_pkg.sv]
// Constants, field layouts and types for the preamp mode and serial register block.
// Assumes a single 100 MHz core clock; every pin is synchronised before use.
// How it works
// RULE_01 - High select or idle override forces idle
// RULE_02 - Polarity bit inverts select pin, resets zero
// RULE_03 - Bank pin picks head range 0-9 or 16-25
// RULE_04 - Servo bit lets both head ranges respond
// RULE_05 - Read/write high reads; bias from pin or override
// RULE_06 - No bias request in read gives read-inactive
// RULE_07 - Write enables current; bias only when requested
// RULE_08 - Servo write: current on, bias forced off
// RULE_09 - Register 0: head select and polarity bit
// RULE_10 - Register 1: test, monitor, power, mode bits
// RULE_11 - Register 2: overshoot and write current code
// RULE_12 - Register 3: six-bit bias current code
// RULE_13 - Register 4: asperity, corner, bandwidth, gain fields
// RULE_14 - Register 5: asperity output, enables, threshold
// RULE_15 - Registers 6, 8, 9 keep their listed bits
// RULE_16 - Register 7: read and write fault selects
// RULE_17 - Registers 10-12: per-head write/read bit pairs
// RULE_18 - Register 13 boost field; register 15 reserved
// RULE_19 - Fault output high on fault, wired-OR capable
// RULE_20 - Open-collector flag on detected thermal asperity
// RULE_21 - Head voltage valid only while enable set
// RULE_22 - Three-wire port, clock no faster than 40 MHz
// RULE_23 - Frame: read flag, address, eight data bits

package pa_pkg;

	// ********************************************************
	// Register offsets
	// ********************************************************
	localparam logic [3:0] PA_OFS_HEAD_SELECT_POLARITY = 4'h0;
	localparam logic [3:0] PA_OFS_MODE_OVERRIDE_CONTROL = 4'h1;
	localparam logic [3:0] PA_OFS_WRITE_CURRENT_OVERSHOOT = 4'h2;
	localparam logic [3:0] PA_OFS_READ_BIAS_CURRENT = 4'h3;
	localparam logic [3:0] PA_OFS_READ_GAIN_BANDWIDTH = 4'h4;
	localparam logic [3:0] PA_OFS_ASPERITY_THRESHOLD_CTRL = 4'h5;
	localparam logic [3:0] PA_OFS_DETECT_CONTROLS = 4'h6;
	localparam logic [3:0] PA_OFS_FAULT_SELECT = 4'h7;
	localparam logic [3:0] PA_OFS_CHANNEL_ENABLE_CODES = 4'h8;
	localparam logic [3:0] PA_OFS_CHANNEL_VOLTAGE_FIELDS = 4'h9;
	localparam logic [3:0] PA_OFS_PER_HEAD_BITS_HIGH = 4'hA;
	localparam logic [3:0] PA_OFS_PER_HEAD_BITS_MID = 4'hB;
	localparam logic [3:0] PA_OFS_PER_HEAD_BITS_LOW = 4'hC;
	localparam logic [3:0] PA_OFS_WRITE_BOOST = 4'hD;
	localparam logic [3:0] PA_OFS_RESERVED_REGISTER = 4'hF;

	// ********************************************************
	// Field positions, reset value and writable bit masks
	// ********************************************************
	localparam int PA_POS_SELECT_POLARITY = 5;
	localparam int PA_POS_ASPERITY_DET_EN = 5;
	localparam logic [7:0] PA_REG_RESET = 8'h00;
	// Unused and reserved bits are not stored and read back as zero; index 15 first
	localparam logic [15:0][7:0] PA_WR_MASK = {
		8'h00, 8'h00, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h7F,
		8'hFF, 8'h7F, 8'hFF, 8'hEF, 8'h3F, 8'hFF, 8'hFF, 8'h3F};

	// ********************************************************
	// Timing and frame figures
	// ********************************************************
	localparam int PA_SER_CLK_MAX_MHZ = 40;
	localparam int PA_CORE_CLK_MHZ = 100;
	// Least core cycles per serial clock phase that the sampler can resolve
	localparam int PA_SER_MIN_PHASE_CYC = (PA_CORE_CLK_MHZ + 2 * PA_SER_CLK_MAX_MHZ - 1) /
		(2 * PA_SER_CLK_MAX_MHZ);
	localparam logic [2:0] PA_HDR_LAST = 3'h4;
	localparam logic [2:0] PA_DATA_LAST = 3'h7;
	localparam int PA_NUM_HEADS = 10;
	localparam logic [3:0] PA_TOP_CHANNEL = 4'h9;

	// ********************************************************
	// Types
	// ********************************************************
	typedef struct packed {
		logic [1:0] test_bits;
		logic head_voltage_output_enable;
		logic power_enable_bit;
		logic servo_write_bit;
		logic bias_override_bit;
		logic idle_override_bit;
		logic clear_bit;
	} pa_mode_reg_t;

	typedef struct packed {
		logic cs;
		logic rw;
		logic bias_enable_pin;
		logic bank_select_pin;
		logic read_fault_det;
		logic write_fault_det;
		logic asperity_det;
		logic serial_enable_pin;
		logic sclk;
		logic serial_data_pin;
	} pa_pins_t;

	typedef struct packed {
		logic write_current_en;
		logic head_bias_en;
	} pa_drive_t;

	typedef enum logic [4:0] {
		PA_MODE_IDLE = 5'h01,
		PA_MODE_READ_INACTIVE = 5'h02,
		PA_MODE_READ = 5'h04,
		PA_MODE_WRITE = 5'h08,
		PA_MODE_SERVO_WRITE = 5'h10
	} pa_mode_t;

	typedef enum logic [3:0] {
		PA_SP_IDLE = 4'h1,
		PA_SP_HEAD = 4'h2,
		PA_SP_DATA = 4'h4,
		PA_SP_DONE = 4'h8
	} pa_sp_t;

endpackage

// [hdl/pa_sync.sv]
// Two-stage synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to clk; only the second stage is read outside.
`timescale 1ns/1ns

module pa_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] nxt_dout;

	// Next values: first stage feeds only the second
	always_comb
	begin
		nxt_meta = din;
		nxt_dout = meta_ff;
	end

	// Both stages clear to zero at power-on
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_ff <= '0;
			dout <= '0;
		end
		else
		begin
			meta_ff <= nxt_meta;
			dout <= nxt_dout;
		end
	end

endmodule

// [hdl/pa_ctrl.sv]
// Mode decode, head mapping and serial register bank of the preamp control.
// Assumes real-time pins and the serial port arrive asynchronously; the serial
// clock is oversampled by clk, so it must stay well below a quarter of clk.
`timescale 1ns/1ns

module pa_ctrl (
	input wire logic clk,
	input wire logic nrst,
	input wire pa_pkg::pa_pins_t pins,
	output logic serial_data_pin_o,
	output logic serial_data_pin_oe,
	output logic fault_output_o,
	output logic fault_output_oe,
	output logic asperity_flag_output_o,
	output logic asperity_flag_output_oe,
	output pa_pkg::pa_mode_t mode_ff,
	output pa_pkg::pa_drive_t drive_ff,
	output logic [9:0] head_onehot_ff,
	output logic head_voltage_output_valid_ff
);
	import pa_pkg::*;

	// ********************************************************
	// Pin synchronisation
	// ********************************************************
	pa_pins_t pins_s;

	pa_sync #(
		.W($bits(pa_pins_t))
	) u_sync (
		.clk(clk),
		.nrst(nrst),
		.din(pins),
		.dout(pins_s)
	);

	// ********************************************************
	// Register bank state
	// ********************************************************
	logic [7:0] regs_ff [0:15];
	logic [7:0] nxt_regs [0:15];
	pa_mode_reg_t mreg;
	logic [4:0] head_select_field;
	logic select_polarity_bit;

	assign mreg = pa_mode_reg_t'(regs_ff[PA_OFS_MODE_OVERRIDE_CONTROL]);
	assign head_select_field = regs_ff[PA_OFS_HEAD_SELECT_POLARITY][4:0];
	assign select_polarity_bit = regs_ff[PA_OFS_HEAD_SELECT_POLARITY][PA_POS_SELECT_POLARITY];

	// ********************************************************
	// Serial port
	// ********************************************************
	pa_sp_t sp_ff;
	pa_sp_t nxt_sp;
	logic sclk_d_ff;
	logic nxt_sclk_d;
	logic en_d_ff;
	logic nxt_en_d;
	logic [2:0] cnt_ff;
	logic [2:0] nxt_cnt;
	logic [7:0] shift_ff;
	logic [7:0] nxt_shift;
	logic rd_flag_ff;
	logic nxt_rd_flag;
	logic [3:0] addr_ff;
	logic [3:0] nxt_addr;
	logic [7:0] rd_shift_ff;
	logic [7:0] nxt_rd_shift;
	logic sdo_ff;
	logic nxt_sdo;
	logic sdo_oe_ff;
	logic nxt_sdo_oe;
	logic sclk_rise;
	logic sclk_fall;
	logic en_rise;
	logic commit;
	logic [7:0] wr_data;

	// Edges are found on the synchronised copies only
	assign sclk_rise = pins_s.sclk & ~sclk_d_ff;
	assign sclk_fall = ~pins_s.sclk & sclk_d_ff;
	assign en_rise = pins_s.serial_enable_pin & ~en_d_ff;
	assign wr_data = {shift_ff[6:0], pins_s.serial_data_pin};
	assign commit = (sp_ff == PA_SP_DATA) && sclk_rise && (cnt_ff == PA_DATA_LAST) && !rd_flag_ff;

	// Frame sequencer: flag, four address bits MSB first, then eight data bits
	always_comb
	begin
		nxt_sp = sp_ff;
		nxt_cnt = cnt_ff;
		nxt_shift = shift_ff;
		nxt_rd_flag = rd_flag_ff;
		nxt_addr = addr_ff;
		nxt_rd_shift = rd_shift_ff;
		nxt_sdo = sdo_ff;
		nxt_sdo_oe = sdo_oe_ff;
		nxt_sclk_d = pins_s.sclk;
		nxt_en_d = pins_s.serial_enable_pin;
		case (sp_ff)
			PA_SP_IDLE:
			begin
				nxt_sdo_oe = 1'b0;
				if (en_rise)
				begin
					nxt_sp = PA_SP_HEAD;
					nxt_cnt = 3'h0;
				end
			end
			PA_SP_HEAD:
			begin
				if (sclk_rise)
				begin
					nxt_shift = {shift_ff[6:0], pins_s.serial_data_pin};
					nxt_cnt = cnt_ff + 3'h1;
					if (cnt_ff == PA_HDR_LAST)
					begin
						// Header complete; a read turns the data line round here
						nxt_rd_flag = shift_ff[3];
						nxt_addr = {shift_ff[2:0], pins_s.serial_data_pin};
						nxt_rd_shift = regs_ff[{shift_ff[2:0], pins_s.serial_data_pin}];
						nxt_sdo_oe = shift_ff[3]; // RULE_23
						nxt_cnt = 3'h0;
						nxt_sp = PA_SP_DATA;
					end
				end
			end
			PA_SP_DATA:
			begin
				if (sclk_fall && rd_flag_ff)
				begin
					// Read data leaves on falling edges, ready for the next rise
					nxt_sdo = rd_shift_ff[7]; // RULE_23
					nxt_rd_shift = {rd_shift_ff[6:0], 1'b0};
				end
				if (sclk_rise)
				begin
					nxt_shift = wr_data;
					nxt_cnt = cnt_ff + 3'h1;
					if (cnt_ff == PA_DATA_LAST)
					begin
						nxt_sp = PA_SP_DONE;
					end
				end
			end
			PA_SP_DONE:
			begin
				// Extra clocks are ignored until the enable drops
				nxt_sp = PA_SP_DONE;
			end
			default:
			begin
				nxt_sp = PA_SP_IDLE;
			end
		endcase
		// Enable low aborts any frame and releases the data line
		if (!pins_s.serial_enable_pin)
		begin
			nxt_sp = PA_SP_IDLE; // RULE_22
			nxt_sdo_oe = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sp_ff <= PA_SP_IDLE;
			cnt_ff <= 3'h0;
			shift_ff <= 8'h00;
			rd_flag_ff <= 1'b0;
			addr_ff <= 4'h0;
			rd_shift_ff <= 8'h00;
			sdo_ff <= 1'b0;
			sdo_oe_ff <= 1'b0;
			sclk_d_ff <= 1'b0;
			en_d_ff <= 1'b0;
		end
		else
		begin
			sp_ff <= nxt_sp;
			cnt_ff <= nxt_cnt;
			shift_ff <= nxt_shift;
			rd_flag_ff <= nxt_rd_flag;
			addr_ff <= nxt_addr;
			rd_shift_ff <= nxt_rd_shift;
			sdo_ff <= nxt_sdo;
			sdo_oe_ff <= nxt_sdo_oe;
			sclk_d_ff <= nxt_sclk_d;
			en_d_ff <= nxt_en_d;
		end
	end

	assign serial_data_pin_o = sdo_ff;
	assign serial_data_pin_oe = sdo_oe_ff;

	// Register write: masks keep unused bits and the reserved register at zero
	always_comb
	begin
		for (int i = 0; i < 16; i++)
		begin
			nxt_regs[i] = regs_ff[i];
		end
		if (commit)
		begin
			nxt_regs[addr_ff] = wr_data & PA_WR_MASK[addr_ff]; // RULE_09 RULE_10 RULE_11 RULE_12
		end
	end

	// Power-on reset clears the bank, so the polarity bit starts low
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < 16; i++)
			begin
				regs_ff[i] <= PA_REG_RESET; // RULE_02
			end
		end
		else
		begin
			for (int i = 0; i < 16; i++)
			begin
				regs_ff[i] <= nxt_regs[i]; // RULE_13 RULE_14 RULE_15 RULE_16 RULE_17 RULE_18
			end
		end
	end

	// ********************************************************
	// Mode decode and head mapping
	// ********************************************************
	logic cs_eff;
	logic bias_req;
	logic lower_hit;
	logic upper_hit;
	logic respond;
	pa_mode_t nxt_mode;
	pa_drive_t nxt_drive;
	logic [9:0] nxt_head;
	logic nxt_hv_valid;
	logic nxt_fault;
	logic nxt_flag;
	logic fault_ff;
	logic flag_ff;

	assign cs_eff = pins_s.cs ^ select_polarity_bit; // RULE_02
	assign bias_req = pins_s.bias_enable_pin | mreg.bias_override_bit;
	assign lower_hit = !head_select_field[4] && (head_select_field[3:0] <= PA_TOP_CHANNEL);
	assign upper_hit = head_select_field[4] && (head_select_field[3:0] <= PA_TOP_CHANNEL);

	// Mode table, priority idle, then read, then servo write, then write
	always_comb
	begin
		nxt_mode = PA_MODE_IDLE;
		nxt_drive = '0;
		if (cs_eff || mreg.idle_override_bit)
		begin
			nxt_mode = PA_MODE_IDLE; // RULE_01
			nxt_drive = '0;
		end
		else if (pins_s.rw)
		begin
			nxt_mode = bias_req ? PA_MODE_READ : PA_MODE_READ_INACTIVE; // RULE_05 RULE_06
			nxt_drive.head_bias_en = bias_req;
		end
		else if (mreg.servo_write_bit)
		begin
			nxt_mode = PA_MODE_SERVO_WRITE; // RULE_08
			nxt_drive.write_current_en = 1'b1;
			nxt_drive.head_bias_en = 1'b0;
		end
		else
		begin
			nxt_mode = PA_MODE_WRITE; // RULE_07
			nxt_drive.write_current_en = 1'b1;
			nxt_drive.head_bias_en = bias_req;
		end
	end

	// Head map; servo write lets both bank halves answer their range
	always_comb
	begin
		if (mreg.servo_write_bit)
		begin
			respond = lower_hit | upper_hit; // RULE_04
		end
		else
		begin
			respond = pins_s.bank_select_pin ? lower_hit : upper_hit; // RULE_03
		end
		nxt_head = 10'h000;
		for (int c = 0; c < PA_NUM_HEADS; c++)
		begin
			nxt_head[c] = respond && (head_select_field[3:0] == 4'(c));
		end
		nxt_hv_valid = mreg.head_voltage_output_enable; // RULE_21
		// Faults only reported in an active mode
		nxt_fault = (nxt_mode != PA_MODE_IDLE) &&
			(pins_s.read_fault_det || pins_s.write_fault_det); // RULE_19
		nxt_flag = (nxt_mode == PA_MODE_READ) && pins_s.asperity_det &&
			regs_ff[PA_OFS_ASPERITY_THRESHOLD_CTRL][PA_POS_ASPERITY_DET_EN]; // RULE_20
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			mode_ff <= PA_MODE_IDLE;
			drive_ff <= '0;
			head_onehot_ff <= 10'h000;
			head_voltage_output_valid_ff <= 1'b0;
			fault_ff <= 1'b0;
			flag_ff <= 1'b0;
		end
		else
		begin
			mode_ff <= nxt_mode;
			drive_ff <= nxt_drive;
			head_onehot_ff <= nxt_head;
			head_voltage_output_valid_ff <= nxt_hv_valid;
			fault_ff <= nxt_fault;
			flag_ff <= nxt_flag;
		end
	end

	// Fault drives high only when set, so other devices may share the wire
	assign fault_output_o = fault_ff; // RULE_19
	assign fault_output_oe = fault_ff;
	// Open collector: pull low while flagged, float otherwise
	assign asperity_flag_output_o = 1'b0; // RULE_20
	assign asperity_flag_output_oe = flag_ff;

	// ********************************************************
	// Assertions
	// ********************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	sequence s_active;
		!cs_eff && !mreg.idle_override_bit;
	endsequence

	sequence s_last_write_bit;
		(sp_ff == PA_SP_DATA) && sclk_rise && (cnt_ff == PA_DATA_LAST) && !rd_flag_ff;
	endsequence

	AST_IDLE_FORCE: assert property ((cs_eff || mreg.idle_override_bit) |=> // RULE_01
		(mode_ff == PA_MODE_IDLE) && (drive_ff == '0))
		else $error("idle not forced");

	AST_POL_INVERT: assert property ((select_polarity_bit && !pins_s.cs) |=> // RULE_02
		mode_ff == PA_MODE_IDLE)
		else $error("select polarity not inverted");

	AST_BANK_UPPER: assert property ((!mreg.servo_write_bit && !pins_s.bank_select_pin && // RULE_03
		head_select_field == 5'h13) |=> head_onehot_ff == 10'h008)
		else $error("upper range map wrong");

	AST_SERVO_BOTH: assert property ((mreg.servo_write_bit && pins_s.bank_select_pin && // RULE_04
		head_select_field == 5'h12) |=> head_onehot_ff == 10'h004)
		else $error("servo override of bank pin failed");

	AST_READ_BIAS: assert property ((s_active ##0 (pins_s.rw && bias_req)) |=> // RULE_05
		(mode_ff == PA_MODE_READ) && drive_ff.head_bias_en && !drive_ff.write_current_en)
		else $error("read mode wrong");

	AST_READ_INACTIVE: assert property ((s_active ##0 (pins_s.rw && !bias_req)) |=> // RULE_06
		(mode_ff == PA_MODE_READ_INACTIVE) && (drive_ff == '0))
		else $error("read-inactive wrong");

	AST_WRITE_BIAS: assert property ((s_active ##0 (!pins_s.rw && !mreg.servo_write_bit)) // RULE_07
		|=> (mode_ff == PA_MODE_WRITE) && drive_ff.write_current_en &&
		(drive_ff.head_bias_en == $past(bias_req)))
		else $error("write mode wrong");

	AST_SERVO_WRITE: assert property ((s_active ##0 (!pins_s.rw && mreg.servo_write_bit)) // RULE_08
		|=> (mode_ff == PA_MODE_SERVO_WRITE) && drive_ff.write_current_en &&
		!drive_ff.head_bias_en)
		else $error("servo write wrong");

	AST_WRITE_COMMIT: assert property (s_last_write_bit |=> // RULE_23
		regs_ff[$past(addr_ff)] == ($past(wr_data) & PA_WR_MASK[$past(addr_ff)]))
		else $error("serial write not stored");

	AST_READ_DRIVE: assert property (((sp_ff == PA_SP_DATA) && rd_flag_ff && // RULE_23
		pins_s.serial_enable_pin) |-> serial_data_pin_oe)
		else $error("read data not driven");

	AST_RESERVED_ZERO: assert property (regs_ff[PA_OFS_RESERVED_REGISTER] == 8'h00) // RULE_18
		else $error("reserved register changed");

	AST_FAULT_OUT: assert property (((nxt_mode != PA_MODE_IDLE) && // RULE_19
		pins_s.write_fault_det) |=> fault_output_o && fault_output_oe)
		else $error("fault not driven");

endmodule

// [verification/pa_host.sv]
// Drive controller model: owns the three serial port pins of the preamp.
// Assumes clk is the 100 MHz core clock; the serial clock is paced from it.
`timescale 1ns/1ns

module pa_host (
	input wire logic clk,
	input wire logic line_in,
	output logic frame_en,
	output logic sclk,
	output logic line_o,
	output logic line_oe
);
	// ********************************************************
	// Pacing
	// ********************************************************
	// Core cycles per serial clock phase; 4 gives 40 ns, the bench may slow it
	int half = 4;

	// Serial clock stands low and the data line is released outside frames
	initial
	begin
		frame_en = 1'b0;
		sclk = 1'b0;
		line_o = 1'b0;
		line_oe = 1'b0;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask

	// ********************************************************
	// Frame
	// ********************************************************
	// Read flag, address MSB first, then eight data bits MSB first
	task automatic frame(input logic rd, input logic [3:0] adr, input logic [7:0] wd,
		output logic [7:0] rdat);
		logic [12:0] bits;
		bits = {rd, adr, wd};
		rdat = 8'h00;
		frame_en <= 1'b1;
		step(half);
		for (int i = 12; i >= 0; i--)
		begin
			line_o <= bits[i];
			line_oe <= !(rd && i < 8); // Let go of the line for the answer
			step(half);
			sclk <= 1'b1;
			if (i < 8)
				rdat[i] = line_in; // Taken at the rise, after a full low phase
			step(half);
			sclk <= 1'b0;
		end
		step(half);
		frame_en <= 1'b0;
		line_oe <= 1'b0;
		line_o <= 1'b0;
		step(6); // Enable low long enough between frames
	endtask
endmodule

// [verification/tb.sv]
// Self-checking bench for the preamp mode decode and serial register bank.
// Assumes pa_host stands for the drive controller on the serial port pins.
`timescale 1ns/1ns

module tb;
	import pa_pkg::*;
	logic clk;
	logic nrst;
	pa_pins_t ctl;
	pa_pins_t pins;
	logic frame_en, sclk, line_o, line_oe, line_w;
	logic sdo, sdoe, fault_o, fault_oe, flag_o, flag_oe, hv_valid;
	pa_mode_t mode;
	pa_drive_t drive;
	logic [9:0] head;
	int fails = 0;
	int checked = 0;
	int cycles = 0;
	logic [7:0] rd;
	logic [3:0] cfg;
	logic [2:0] pv;
	logic act, bias, lo, hi;
	pa_mode_t em;
	logic [1:0] ed;
	logic [9:0] eh;
	logic [7:0] pat [2] = '{8'hA5, 8'h5A};
	// Stored bits of each register; unused and reserved bits read as zero
	logic [7:0] mask [16] = '{8'h3F, 8'hFF, 8'hFF, 8'h3F, 8'hEF, 8'hFF, 8'h7F, 8'hFF,
		8'h7F, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'h00, 8'h00};

	// ********************************************************
	// Clock, wiring and instances
	// ********************************************************
	initial
		clk = 1'b0;
	always #5 clk = ~clk;

	// Data line is pulled down when neither side drives it
	assign line_w = sdoe ? sdo : (line_oe ? line_o : 1'b0);
	assign pins = {ctl[9:3], frame_en, sclk, line_w};

	pa_host u_host (.clk(clk), .line_in(line_w), .frame_en(frame_en), .sclk(sclk),
		.line_o(line_o), .line_oe(line_oe));

	pa_ctrl u_dut (.clk(clk), .nrst(nrst), .pins(pins), .serial_data_pin_o(sdo),
		.serial_data_pin_oe(sdoe), .fault_output_o(fault_o), .fault_output_oe(fault_oe),
		.asperity_flag_output_o(flag_o), .asperity_flag_output_oe(flag_oe), .mode_ff(mode),
		.drive_ff(drive), .head_onehot_ff(head), .head_voltage_output_valid_ff(hv_valid));

	// ********************************************************
	// Checking and access tasks
	// ********************************************************
	task automatic note(input logic bad, input logic [9:0] got, input logic [9:0] exp);
		checked++;
		if (bad)
		begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		note(got !== exp, {2'b00, got}, {2'b00, exp});
	endtask

	task automatic chk_mode(input pa_mode_t got, input pa_mode_t exp);
		note(got !== exp, {5'h00, got}, {5'h00, exp});
	endtask

	task automatic chk_bits(input logic [9:0] got, input logic [9:0] exp);
		note(got !== exp, got, exp);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] x;
		u_host.frame(1'b0, a, d, x);
	endtask

	// Read, then confirm the device has let go of the data line
	task automatic rdr(input logic [3:0] a, output logic [7:0] d);
		u_host.frame(1'b1, a, 8'h00, d);
		chk_bits({9'h000, sdoe}, 10'h000);
	endtask

	// Pins pass a synchroniser, so give them a few cycles to land
	task automatic settle();
		repeat (4) @(posedge clk);
	endtask

	task automatic wrap_up();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// A hang is cut short well past the expected run of about 25k cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			fails++;
			wrap_up();
		end
	end

	// ********************************************************
	// Scenarios
	// ********************************************************
	initial
	begin
		nrst = 1'b0;
		ctl = '0;
		ctl.cs = 1'b1;
		ctl.bank_select_pin = 1'b1;
		repeat (6) @(posedge clk);
		chk_mode(mode, PA_MODE_IDLE);
		nrst <= 1'b1;
		settle();
		// Reset values, read with a slow controller
		u_host.half = 7;
		for (int a = 0; a < 16; a++)
		begin
			rdr(4'(a), rd);
			chk_reg(rd, 8'h00);
		end
		u_host.half = 4;
		// Every bit in both states; unused bits must not stick
		foreach (pat[p])
			for (int a = 0; a < 16; a++)
			begin
				wr(4'(a), pat[p]);
				rdr(4'(a), rd);
				chk_reg(rd, pat[p] & mask[a]);
			end
		// Mode table: {polarity, servo, bias override, idle override} by {cs, rw, bias pin}
		wr(4'h5, 8'h20);
		for (int r = 0; r < 16; r++)
		begin
			cfg = 4'(r);
			wr(4'h0, {2'b00, cfg[3], 5'h00});
			wr(4'h1, {2'b00, cfg[3], 1'b0, cfg[2], cfg[1], cfg[0], 1'b0});
			for (int p = 0; p < 8; p++)
			begin
				pv = 3'(p);
				ctl.cs <= pv[2];
				ctl.rw <= pv[1];
				ctl.bias_enable_pin <= pv[0];
				// Read and write faults take turns so both detector inputs are exercised
				ctl.read_fault_det <= pv[0] & pv[1];
				ctl.write_fault_det <= pv[0] & !pv[1];
				ctl.asperity_det <= pv[0];
				settle();
				act = ((pv[2] ^ cfg[3]) == 1'b0) && !cfg[0];
				bias = pv[0] | cfg[1];
				em = !act ? PA_MODE_IDLE : pv[1] ? (bias ? PA_MODE_READ : PA_MODE_READ_INACTIVE)
					: cfg[2] ? PA_MODE_SERVO_WRITE : PA_MODE_WRITE;
				ed = !act ? 2'b00 : pv[1] ? {1'b0, bias} : {1'b1, bias & !cfg[2]};
				chk_mode(mode, em);
				chk_bits({8'h00, drive}, {8'h00, ed});
				chk_bits({8'h00, fault_o, fault_oe}, {8'h00, {2{act & pv[0]}}});
				chk_bits({8'h00, flag_o, flag_oe}, {9'h000, (em == PA_MODE_READ) && pv[0]});
				chk_bits({9'h000, hv_valid}, {9'h000, cfg[3]});
			end
		end
		// Head mapping over every head select value, both bank pin levels
		ctl.cs <= 1'b0;
		ctl.rw <= 1'b1;
		for (int s = 0; s < 2; s++)
		begin
			wr(4'h1, {4'h0, 1'(s), 3'h0});
			for (int h = 0; h < 32; h++)
			begin
				wr(4'h0, {3'h0, 5'(h)});
				for (int b = 0; b < 2; b++)
				begin
					ctl.bank_select_pin <= 1'(b);
					settle();
					lo = (s == 1 || b == 1) && h < 10;
					hi = (s == 1 || b == 0) && h >= 16 && h < 26;
					eh = lo ? 10'h001 << h : hi ? 10'h001 << (h - 16) : 10'h000;
					chk_bits(head, eh);
				end
			end
		end
		wrap_up();
	end
endmodule
